/* common/hls_pkg.sv */
// Package of constants, types and structs for the host link select and lockout block.
package hls_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int DEGLITCH_SHORT_MS = 1;
    localparam int DEGLITCH_LONG_MS = 10;
    localparam int DEGLITCH_SHORT_CYC = CLK_FREQ_HZ / 1000 * DEGLITCH_SHORT_MS;
    localparam int DEGLITCH_LONG_CYC = CLK_FREQ_HZ / 1000 * DEGLITCH_LONG_MS;
    localparam int TURNAROUND_MS = 15;
    localparam int TURNAROUND_CYC = CLK_FREQ_HZ / 1000 * TURNAROUND_MS;

    // ----------------------------------------------------------------
    // Field encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] LINK_SEL_SPI = 2'h0;
    localparam logic [1:0] LINK_SEL_I2C = 2'h1;
    localparam logic [1:0] LINK_SEL_WIRE = 2'h2;
    localparam logic [1:0] LINK_SEL_RESET = 2'h0;
    localparam logic FILTER_SEL_RESET = 1'b0;
    localparam logic [7:0] LOCK_CODE = 8'hAA;
    localparam logic [7:0] UNLOCK_CODE = 8'h00;
    localparam int SPI_WORD_W = 8;

    // Error flag positions in the two single-wire error status words.
    localparam int ERR1_BAUD_BIT = 0;
    localparam int ERR1_SYNC_BIT = 1;
    localparam int ERR2_STOP_BIT = 0;
    localparam int ERR2_CMD_BIT = 1;

    typedef enum logic [2:0] {
        ACT_IDLE,
        ACT_HIGH,
        ACT_WAIT_LOW,
        ACT_RETURN,
        ACT_DONE
    } hls_act_state_t;

    typedef struct packed {
        logic baud_range;
        logic bad_sync;
        logic bad_stop;
        logic bad_cmd;
    } hls_wire_err_t;

    typedef struct packed {
        logic [1:0] link_sel;
        logic filter_sel;
        logic transceiver_route_switch_en;
        logic mem_owner;
    } hls_ctrl_t;

endpackage : hls_pkg

/* rtl/hls_buf2.sv */
// Two-entry valid/ready buffer with honest full and empty.
`timescale 1ns/1ns
`default_nettype none
module hls_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    if (DEPTH != 2)
    begin : g_depth_check
        $error("hls_buf2 supports a depth of two only");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign in_ready_out = (count_reg != 2'h2);
    assign out_valid_out = (count_reg != 2'h0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_reg[rd_ptr_reg];

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end
        else
        begin
            if (push)
            begin
                mem_reg[wr_ptr_reg] <= in_data_in;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule : hls_buf2
`default_nettype wire

/* rtl/hls_sync.sv */
// Two-flip-flop synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ns
`default_nettype none
module hls_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : hls_sync
`default_nettype wire

/* rtl/hls_top.sv */
// Host link select, single-wire activation, SPI slave shifter and host memory lockout.
`timescale 1ns/1ns
`default_nettype none
module hls_top
    import hls_pkg::*;
#(
    parameter int DEGLITCH_SHORT = DEGLITCH_SHORT_CYC,
    parameter int DEGLITCH_LONG = DEGLITCH_LONG_CYC,
    parameter int WORD_W = SPI_WORD_W
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // Control written by software.
    input wire hls_ctrl_t ctrl_in,
    input wire logic lock_wr_in,
    input wire logic [7:0] lock_data_in,
    input wire logic watchdog_rst_in,
    // Analog comparator outputs at the shared pin.
    input wire logic over_54v_in,
    input wire logic act_level_in,
    // Single-wire line and its controller.
    input wire logic wire_rx_in,
    input wire logic wire_tx_req_in,
    input wire logic wire_tx_bit_in,
    input wire hls_wire_err_t wire_err_in,
    output logic wire_out,
    output logic wire_oe_out,
    output logic [7:0] wire_err1_out,
    output logic [7:0] wire_err2_out,
    input wire logic [1:0] wire_err_clr_in,
    // Pin routing.
    output logic dac_on_out,
    output logic transceiver_route_switch_route_out,
    output logic wire_ctrl_en_out,
    output logic wire_activation_irq_out,
    // SPI pins.
    input wire logic spi_cs_n_in,
    input wire logic spi_sck_in,
    input wire logic spi_sdi_in,
    output logic spi_sdo_out,
    output logic spi_sdo_oe_out,
    // Received SPI words and words to return.
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [WORD_W-1:0] rx_data_out,
    input wire logic [WORD_W-1:0] tx_data_in,
    output logic spi_overrun_out,
    // I2C pins routed on the GPIO lines.
    output logic i2c_pins_en_out,
    // Memory arbitration.
    output logic host_mem_grant_out,
    output logic host_test_grant_out,
    output logic cpu_mem_grant_out,
    output logic locked_out
);
    if (DEGLITCH_SHORT < 1 || DEGLITCH_LONG < DEGLITCH_SHORT || WORD_W < 2)
    begin : g_param_check
        $error("hls_top parameter values not supported");
    end

    function automatic int unsigned deglitch_len(input logic sel);
        deglitch_len = sel ? DEGLITCH_LONG : DEGLITCH_SHORT;
    endfunction : deglitch_len

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic over_s;
    logic lvl_s;
    logic line_low_s;
    logic cs_s;
    logic sck_s;
    logic sdi_s;

    // Line and chip select enter inverted, so that the synchroniser's reset value
    // matches their idle level and no false selection follows reset.
    hls_sync #(.WIDTH(6)) u_sync (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .async_in({over_54v_in, act_level_in, !wire_rx_in, !spi_cs_n_in, spi_sck_in,
            spi_sdi_in}),
        .sync_out({over_s, lvl_s, line_low_s, cs_s, sck_s, sdi_s})
    );

    // ----------------------------------------------------------------
    // Link selection and pin routing
    // ----------------------------------------------------------------
    logic wire_sel;
    logic act_enabled;
    logic dac_base;
    hls_act_state_t act_state_reg;
    hls_act_state_t act_state_next;

    assign wire_sel = (ctrl_in.link_sel == LINK_SEL_WIRE);
    assign wire_ctrl_en_out = wire_sel;
    assign transceiver_route_switch_route_out = ctrl_in.transceiver_route_switch_en;
    assign i2c_pins_en_out = (ctrl_in.link_sel == LINK_SEL_I2C);
    // The DAC drives the pin unless single-wire is selected or the pin is routed to the transceiver.
    assign dac_base = !wire_sel && !ctrl_in.transceiver_route_switch_en;
    // SPI is the reset selection, so it only counts once software picks it with
    // host ownership; otherwise activation would never be possible.
    assign act_enabled = dac_base && !i2c_pins_en_out
        && !(ctrl_in.link_sel == LINK_SEL_SPI && ctrl_in.mem_owner);

    // Overvoltage kills the DAC at once; during the return period it is back on.
    assign dac_on_out = dac_base && !over_s
        && (act_state_reg != ACT_HIGH || !lvl_s);

    // ----------------------------------------------------------------
    // Activation deglitch sequence
    // ----------------------------------------------------------------
    logic [31:0] tmr_reg;
    logic tmr_done;
    logic irq_reg;

    assign tmr_done = (tmr_reg >= deglitch_len(ctrl_in.filter_sel));

    always_comb
    begin
        act_state_next = act_state_reg;
        case (act_state_reg)
            ACT_IDLE:
                if (act_enabled && lvl_s)
                    act_state_next = ACT_HIGH;
            ACT_HIGH:
                if (!lvl_s)
                    act_state_next = ACT_IDLE;
                else if (tmr_done)
                    act_state_next = ACT_WAIT_LOW;
            ACT_WAIT_LOW:
                if (!lvl_s)
                    act_state_next = ACT_RETURN;
            ACT_RETURN:
                if (lvl_s)
                    act_state_next = ACT_WAIT_LOW;
                else if (tmr_done)
                    act_state_next = ACT_DONE;
            ACT_DONE:
                act_state_next = ACT_IDLE;
            default:
                act_state_next = ACT_IDLE;
        endcase
        if (!act_enabled)
            act_state_next = ACT_IDLE;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            act_state_reg <= ACT_IDLE;
        else
            act_state_reg <= act_state_next;
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            tmr_reg <= '0;
        else if (act_state_next != act_state_reg)
            tmr_reg <= '0;
        else if (!tmr_done)
            tmr_reg <= tmr_reg + 32'h1;
    end

    // One-cycle interrupt pulse at the end of the return period.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            irq_reg <= 1'b0;
        else
            irq_reg <= (act_state_reg == ACT_DONE);
    end
    assign wire_activation_irq_out = irq_reg;

    // ----------------------------------------------------------------
    // Single-wire line driver and error status
    // ----------------------------------------------------------------
    logic wire_drv_reg;
    logic [7:0] err1_reg;
    logic [7:0] err2_reg;

    // Open drain: only a dominant zero is driven, and only on command.
    // A dominant bit starts only on a recessive line, then holds against its own echo.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            wire_drv_reg <= 1'b0;
        else
            wire_drv_reg <= wire_sel && ctrl_in.transceiver_route_switch_en && wire_tx_req_in
                && !wire_tx_bit_in && (!line_low_s || wire_drv_reg);
    end
    assign wire_out = 1'b0;
    assign wire_oe_out = wire_drv_reg;

    // Set wins over clear so an error in the clearing cycle is kept.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            err1_reg <= 8'h00;
            err2_reg <= 8'h00;
        end
        else
        begin
            if (wire_err_clr_in[0])
                err1_reg <= 8'h00;
            if (wire_err_clr_in[1])
                err2_reg <= 8'h00;
            if (wire_err_in.baud_range)
                err1_reg[ERR1_BAUD_BIT] <= 1'b1;
            if (wire_err_in.bad_sync)
                err1_reg[ERR1_SYNC_BIT] <= 1'b1;
            if (wire_err_in.bad_stop)
                err2_reg[ERR2_STOP_BIT] <= 1'b1;
            if (wire_err_in.bad_cmd)
                err2_reg[ERR2_CMD_BIT] <= 1'b1;
        end
    end
    assign wire_err1_out = err1_reg;
    assign wire_err2_out = err2_reg;

    // ----------------------------------------------------------------
    // SPI slave shifter
    // ----------------------------------------------------------------
    logic spi_active;
    logic sck_d_reg;
    logic sck_rise;
    logic [WORD_W-1:0] sh_in_reg;
    logic [WORD_W-1:0] sh_out_reg;
    logic [$clog2(WORD_W)-1:0] bit_cnt_reg;
    logic word_valid_reg;
    logic [WORD_W-1:0] word_reg;
    logic buf_ready;
    logic overrun_reg;
    logic last_bit;

    assign spi_active = (ctrl_in.link_sel == LINK_SEL_SPI) && cs_s;
    assign last_bit = (bit_cnt_reg == ($clog2(WORD_W))'(WORD_W - 1));

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            sck_d_reg <= 1'b0;
        else
            sck_d_reg <= sck_s;
    end
    assign sck_rise = sck_s && !sck_d_reg;

    // Held in reset whenever chip select is high.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sh_in_reg <= '0;
            sh_out_reg <= '0;
            bit_cnt_reg <= '0;
        end
        else if (!spi_active)
        begin
            sh_in_reg <= '0;
            sh_out_reg <= tx_data_in;
            bit_cnt_reg <= '0;
        end
        else if (sck_rise)
        begin
            sh_in_reg <= {sh_in_reg[WORD_W-2:0], sdi_s};
            bit_cnt_reg <= last_bit ? '0 : bit_cnt_reg + 1'b1;
            sh_out_reg <= last_bit ? tx_data_in : {sh_out_reg[WORD_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            word_valid_reg <= 1'b0;
            word_reg <= '0;
            overrun_reg <= 1'b0;
        end
        else
        begin
            word_valid_reg <= spi_active && sck_rise && last_bit;
            if (spi_active && sck_rise && last_bit)
                word_reg <= {sh_in_reg[WORD_W-2:0], sdi_s};
            // A word finished with the buffer full is flagged, sticky until reset.
            if (word_valid_reg && !buf_ready)
                overrun_reg <= 1'b1;
        end
    end
    assign spi_overrun_out = overrun_reg;

    hls_buf2 #(.WIDTH(WORD_W), .DEPTH(2)) u_buf (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .in_valid_in(word_valid_reg),
        .in_ready_out(buf_ready),
        .in_data_in(word_reg),
        .out_valid_out(rx_valid_out),
        .out_ready_in(rx_ready_in),
        .out_data_out(rx_data_out)
    );

    assign spi_sdo_out = sh_out_reg[WORD_W-1];
    assign spi_sdo_oe_out = spi_active;

    // ----------------------------------------------------------------
    // Host memory lockout and ownership
    // ----------------------------------------------------------------
    logic locked_reg;

    // The device reset or a write of the unlock code clears the lock; a watchdog reset of the processor does not.
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            locked_reg <= 1'b0;
        else if (lock_wr_in && lock_data_in == LOCK_CODE)
            locked_reg <= 1'b1;
        else if (lock_wr_in && lock_data_in == UNLOCK_CODE)
            locked_reg <= 1'b0;
    end
    assign locked_out = locked_reg;

    assign host_test_grant_out = 1'b1;
    assign host_mem_grant_out = ctrl_in.mem_owner && !locked_reg;
    assign cpu_mem_grant_out = !ctrl_in.mem_owner && !watchdog_rst_in;
endmodule : hls_top
`default_nettype wire

/* sim/hls_chk.sv */
// Port-level checker for the host link select block, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module hls_chk
    import hls_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire hls_ctrl_t ctrl_in,
    input wire logic lock_wr_in,
    input wire logic [7:0] lock_data_in,
    input wire logic watchdog_rst_in,
    input wire logic wire_tx_req_in,
    input wire logic wire_oe_out,
    input wire logic dac_on_out,
    input wire logic transceiver_route_switch_route_out,
    input wire logic wire_ctrl_en_out,
    input wire logic wire_activation_irq_out,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdo_oe_out,
    input wire logic host_mem_grant_out,
    input wire logic cpu_mem_grant_out,
    input wire logic locked_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!resetn_in);

    property p_wire_sel;
        ctrl_in.link_sel == LINK_SEL_WIRE |-> wire_ctrl_en_out && !dac_on_out;
    endproperty
    a_wire_sel: assert property (p_wire_sel) else $error("wire select left DAC on");
    property p_pin; ctrl_in.transceiver_route_switch_en |-> transceiver_route_switch_route_out && !dac_on_out; endproperty
    a_pin: assert property (p_pin) else $error("pin not routed to transceiver");
    property p_lock; lock_wr_in && lock_data_in == LOCK_CODE |=> locked_out; endproperty
    a_lock: assert property (p_lock) else $error("lock code ignored");
    property p_unlock;
        locked_out && lock_wr_in && lock_data_in == UNLOCK_CODE |=> !locked_out;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock code ignored");
    property p_keep;
        watchdog_rst_in && !lock_wr_in |=> locked_out == $past(locked_out);
    endproperty
    a_keep: assert property (p_keep) else $error("lock changed in processor reset");
    property p_host; host_mem_grant_out == (ctrl_in.mem_owner && !locked_out); endproperty
    a_host: assert property (p_host) else $error("host grant wrong");
    property p_one; !(host_mem_grant_out && cpu_mem_grant_out); endproperty
    a_one: assert property (p_one) else $error("memory granted twice");
    property p_irq; wire_activation_irq_out |=> !wire_activation_irq_out; endproperty
    a_irq: assert property (p_irq) else $error("interrupt longer than a cycle");
    property p_sdo_z; spi_cs_n_in [*4] |-> !spi_sdo_oe_out; endproperty
    a_sdo_z: assert property (p_sdo_z) else $error("SDO driven while deselected");
    property p_txq; !wire_tx_req_in [*3] |-> !wire_oe_out; endproperty
    a_txq: assert property (p_txq) else $error("wire driven uncommanded");
endmodule : hls_chk

bind hls_top hls_chk hls_chk_i (.sys_clk_in, .resetn_in, .ctrl_in, .lock_wr_in, .lock_data_in,
    .watchdog_rst_in, .wire_tx_req_in, .wire_oe_out, .dac_on_out, .transceiver_route_switch_route_out,
    .wire_ctrl_en_out, .wire_activation_irq_out, .spi_cs_n_in, .spi_sdo_oe_out,
    .host_mem_grant_out, .cpu_mem_grant_out, .locked_out);
`default_nettype wire

/* sim/hls_spi_master.sv */
// Behavioural SPI master standing on the far side of the block's SPI pins.
`timescale 1ns/1ns
`default_nettype none
module hls_spi_master #(
    parameter int HALF_NS = 80
) (
    output logic cs_n_out,
    output logic sck_out,
    output logic sdi_out,
    input wire logic sdo_in,
    input wire logic sdo_oe_in
);
    initial
    begin
        cs_n_out = 1'b1;
        sck_out = 1'b0;
        sdi_out = 1'b0;
    end

    // SCK stands low outside frames; SDI is flipped after the last bit, before chip select rises, so no stale bit lingers.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        cs_n_out = 1'b0;
        #(HALF_NS);
        for (int i = 7; i >= 0; i--)
        begin
            sdi_out = tx[i];
            #(HALF_NS);
            rx[i] = sdo_oe_in ? sdo_in : 1'bx;
            sck_out = 1'b1;
            #(HALF_NS);
            sck_out = 1'b0;
        end
        sdi_out = ~sdi_out;
        #(HALF_NS);
        cs_n_out = 1'b1;
        #(2 * HALF_NS);
    endtask : xfer
endmodule : hls_spi_master
`default_nettype wire

/* sim/testbench.sv */
// Self-checking bench for the host link select and lockout block.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import hls_pkg::*;
();
    localparam int DS = 20;
    localparam int DL = 50;
    // Turnaround before the first single-wire command, scaled like the long filter time.
    localparam int TA = 75;
    logic sys_clk_in, resetn_in, lock_wr_in, watchdog_rst_in, over_54v_in, act_level_in;
    logic wire_rx_in, wire_tx_req_in, wire_tx_bit_in, wire_oe_out, dac_on_out, transceiver_route_switch_route_out;
    logic wire_ctrl_en_out, wire_activation_irq_out, spi_cs_n_in, spi_sck_in, spi_sdi_in, wire_out;
    logic spi_sdo_out, spi_sdo_oe_out, rx_valid_out, rx_ready_in, spi_overrun_out;
    logic i2c_pins_en_out, host_mem_grant_out, host_test_grant_out, cpu_mem_grant_out, locked_out;
    logic [7:0] lock_data_in, wire_err1_out, wire_err2_out, rx_data_out, tx_data_in, rd, e1, e2;
    logic [1:0] wire_err_clr_in;
    hls_ctrl_t ctrl_in;
    hls_wire_err_t wire_err_in;
    logic [2:0] mode [5] = '{3'h5, 3'h4, 3'h3, 3'h2, 3'h0};
    logic [3:0] expd [5] = '{4'h6, 4'h2, 4'h5, 4'h9, 4'h8};
    logic [1:0] txs [3] = '{2'h2, 2'h3, 2'h0};
    logic [3:0] pins;
    int mismatches, n_checks;

    assign pins = {dac_on_out, transceiver_route_switch_route_out, wire_ctrl_en_out, i2c_pins_en_out};
    // The single-wire line has a pull-up, so it reads low only while the block pulls it.
    assign wire_rx_in = !wire_oe_out;

    hls_top #(.DEGLITCH_SHORT(DS), .DEGLITCH_LONG(DL)) hls_top_i (.sys_clk_in, .resetn_in,
        .ctrl_in, .lock_wr_in, .lock_data_in, .watchdog_rst_in, .over_54v_in, .act_level_in,
        .wire_rx_in, .wire_tx_req_in, .wire_tx_bit_in, .wire_err_in, .wire_out, .wire_oe_out,
        .wire_err1_out, .wire_err2_out, .wire_err_clr_in, .dac_on_out, .transceiver_route_switch_route_out,
        .wire_ctrl_en_out, .wire_activation_irq_out, .spi_cs_n_in, .spi_sck_in, .spi_sdi_in,
        .spi_sdo_out, .spi_sdo_oe_out, .rx_valid_out, .rx_ready_in, .rx_data_out, .tx_data_in,
        .spi_overrun_out, .i2c_pins_en_out, .host_mem_grant_out, .host_test_grant_out,
        .cpu_mem_grant_out, .locked_out);

    hls_spi_master hls_spi_master_i (.cs_n_out(spi_cs_n_in), .sck_out(spi_sck_in),
        .sdi_out(spi_sdi_in), .sdo_in(spi_sdo_out), .sdo_oe_in(spi_sdo_oe_out));

    initial
    begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : cyc

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Holds the overvoltage for hold cycles, then returns the pin and waits for the interrupt.
    task automatic activate(input int hold, input int d, input logic want);
        int n;
        n = 0;
        {over_54v_in, act_level_in} = 2'h3;
        cyc(hold);
        chk("dac_off_high", 1'b0, dac_on_out);
        {over_54v_in, act_level_in} = 2'h0;
        while (n < 2 * d + 20 && wire_activation_irq_out !== 1'b1)
        begin
            cyc(1);
            n++;
            if (want && n == d / 2)
                chk("dac_on_return", 1'b1, dac_on_out);
        end
        chk("irq_seen", want, wire_activation_irq_out);
        if (want && wire_activation_irq_out !== 1'b1)
            test_done();
        if (want)
            chk("irq_delay", 1'b1, n >= d && n <= d + 6);
        cyc(5);
    endtask : activate

    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        cyc(1);
        while (rx_valid_out !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (n == 100)
        begin
            mismatches++;
            test_done();
        end
        chk("rx_word", exp, rx_data_out);
        rx_ready_in = 1'b1;
        cyc(1);
        rx_ready_in = 1'b0;
    endtask : pop

    task automatic lock(input logic [7:0] code);
        lock_data_in = code;
        lock_wr_in = 1'b1;
        cyc(1);
        lock_wr_in = 1'b0;
        cyc(1);
    endtask : lock

    initial
    begin
        mismatches = 0;
        n_checks = 0;
        resetn_in = 1'b0;
        ctrl_in = '0;
        {lock_wr_in, watchdog_rst_in, over_54v_in, act_level_in, wire_tx_req_in} = '0;
        {wire_tx_bit_in, rx_ready_in, wire_err_clr_in, wire_err_in} = '0;
        lock_data_in = 8'h00;
        tx_data_in = 8'h00;
        repeat (3) @(negedge sys_clk_in);
        resetn_in = 1'b1;
        cyc(3);
        chk("reset_flags", 8'h0E, {locked_out, wire_activation_irq_out, spi_overrun_out,
            rx_valid_out, dac_on_out, host_test_grant_out, cpu_mem_grant_out,
            host_mem_grant_out});
        chk("reset_errors", 16'h0000, {wire_err1_out, wire_err2_out});
        $display("test reset done");
        // A short glitch must not count towards the filter time.
        {over_54v_in, act_level_in} = 2'h3;
        cyc(3 * DS / 4);
        {over_54v_in, act_level_in} = 2'h0;
        cyc(3);
        activate(3 * DS / 4, DS, 1'b0);
        activate(DS + 10, DS, 1'b1);
        ctrl_in.filter_sel = 1'b1;
        activate(DS + 10, DL, 1'b0);
        activate(DL + 10, DL, 1'b1);
        ctrl_in = {LINK_SEL_I2C, 3'h0};
        activate(DS + 10, DS, 1'b0);
        $display("test activation done");
        for (int i = 0; i < 5; i++)
        begin
            {ctrl_in.link_sel, ctrl_in.transceiver_route_switch_en} = mode[i];
            cyc(2);
            chk("pin_routing", expd[i], pins);
        end
        ctrl_in.link_sel = LINK_SEL_WIRE;
        cyc(1);
        ctrl_in.transceiver_route_switch_en = 1'b1;
        cyc(TA);
        for (int i = 0; i < 3; i++)
        begin
            {wire_tx_req_in, wire_tx_bit_in} = txs[i];
            cyc(3);
            chk("wire_drive", {txs[i][1] & ~txs[i][0], 1'b0}, {wire_oe_out, wire_out});
        end
        $display("test routing done");
        watchdog_rst_in = 1'b1;
        ctrl_in = {LINK_SEL_I2C, 3'h1};
        cyc(2);
        ctrl_in.link_sel = LINK_SEL_SPI;
        cyc(2);
        chk("spi_grants", 2'h2, {host_mem_grant_out, cpu_mem_grant_out});
        tx_data_in = 8'h3C;
        hls_spi_master_i.xfer(8'hA5, rd);
        chk("sdo_word", 8'h3C, rd);
        hls_spi_master_i.xfer(8'h5A, rd);
        chk("no_overrun", 1'b0, spi_overrun_out);
        hls_spi_master_i.xfer(8'h81, rd);
        chk("overrun", 1'b1, spi_overrun_out);
        pop(8'hA5);
        pop(8'h5A);
        chk("drained", 1'b0, rx_valid_out);
        $display("test spi done");
        lock(8'hAA);
        chk("lock_on", 2'h2, {locked_out, host_mem_grant_out});
        lock(8'h55);
        {ctrl_in.mem_owner, watchdog_rst_in} = 2'h0;
        cyc(1);
        chk("lock_kept", 2'h3, {locked_out, cpu_mem_grant_out});
        ctrl_in.mem_owner = 1'b1;
        lock(8'h00);
        chk("lock_off", 2'h1, {locked_out, host_mem_grant_out});
        $display("test lock done");
        for (int i = 0; i < 4; i++)
        begin
            wire_err_in = 4'h8 >> i;
            cyc(1);
            wire_err_in = '0;
            cyc(2);
            {e1, e2} = 16'h0000;
            e1[ERR1_BAUD_BIT] = (i == 0);
            e1[ERR1_SYNC_BIT] = (i == 1);
            e2[ERR2_STOP_BIT] = (i == 2);
            e2[ERR2_CMD_BIT] = (i == 3);
            chk("wire_errors", {e1, e2}, {wire_err1_out, wire_err2_out});
            wire_err_clr_in = 2'h3;
            cyc(1);
            wire_err_clr_in = 2'h0;
        end
        $display("test errors done");
        test_done();
    end
endmodule : testbench
`default_nettype wire
